// ==== verilog/octal_drv_pkg.sv ====
// Purpose: Shared constants and types for the octal low-side driver control
// Assumes: One 20 MHz core clock; every pin sampled through three flip-flops
// Notes: Register offsets are byte addresses on the plain register port
package octal_drv_pkg;

   // Channel count and widths
   localparam int CHANNELS = 8;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_MASK = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_DRIVE = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_FAULT = 4'hc;

   // Status bit positions
   localparam int STAT_FAULT = 0;
   localparam int STAT_OVERTEMP = 1;
   localparam int STAT_LATCHED = 2;
   localparam int STAT_W = 3;

   // Values after reset
   localparam logic [CHANNELS-1:0] CHAN_RST = 8'h00;
   localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
   localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
   localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

   // Pin sampling depth
   localparam int SYNC_STAGES = 3;

   // Pins from outside the core clock domain, travelling together
   typedef struct packed {
      logic shift_clk;
      logic serial_in;
      logic latch_strobe;
      logic enable_n;
      logic overtemp_detect;
      logic undervolt_detect;
      logic [CHANNELS-1:0] overcurrent_detect;
   } pins_t;

   // Pins idle with the drivers disabled
   localparam pins_t PINS_RST = '{shift_clk: 1'b0, serial_in: 1'b0, latch_strobe: 1'b0,
      enable_n: 1'b1, overtemp_detect: 1'b0, undervolt_detect: 1'b0,
      overcurrent_detect: 8'h00};

endpackage

// ==== verilog/pin_filter.sv ====
// Purpose: Three-stage sampler for asynchronous pins with agreement filter
// Assumes: Inputs may change at any time relative to core_clk_i
// Notes: Output moves only when the second and third stages agree
`timescale 1ns/10ps
module pin_filter import octal_drv_pkg::*; #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] clean_o
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // Sampling chain; stage1 feeds stage2 only
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         stage1 <= RST;
         stage2 <= RST;
         stage3 <= RST;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Per bit, accept a level once two samples agree; filters single glitches
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         clean_o <= RST;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (stage2[i] == stage3[i]) begin
               clean_o[i] <= stage3[i];
            end
         end
      end
   end

endmodule

// ==== verilog/octal_drv_ctrl.sv ====
// Purpose: Control logic of an eight-channel low-side driver with serial load
// Assumes: core_clk_i far faster than the shift clock; pins reach it async
// Notes: Shift clock edges are found by sampling, so the pin adds latency
// Behaviour
// - Over-current on a channel latches only that output off.
// - Latched-off output obeys its bit again at next latched word.
// - Fault flag low while any channel fault latch is set.
// - Fault latches and flag hold until next strobe, cleared there.
// - Over-temperature indication forces every output off while active.
// - Shifted data leaves on the serial output for cascading.
// - After a strobe each latched bit drives its output: 1 on, 0 off.
// - Common enable gates the drivers and the load into the data buffer.
// - Serial input captured into eight-stage register on shift clock rise.
// - Strobe high passes register to buffer; strobe fall holds it.
// - Enable high holds outputs off; enable low makes the load transparent.
// - Power-on or under-voltage reset forces all outputs off.
`timescale 1ns/10ps
module octal_drv_ctrl import octal_drv_pkg::*; (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic shift_clk_i,
   input wire logic serial_in_i,
   input wire logic latch_strobe_i,
   input wire logic enable_n_i,
   input wire logic overtemp_detect_i,
   input wire logic undervolt_detect_i,
   input wire logic [CHANNELS-1:0] overcurrent_detect_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   output logic [CHANNELS-1:0] power_output_o,
   output logic serial_out_o,
   output logic fault_flag_n_o,
   output logic irq_o
);

   pins_t raw_pins;
   pins_t pins;
   logic prev_shift_clk;
   logic prev_strobe;
   logic shift_rise;
   logic strobe_fall;
   logic [CHANNELS-1:0] shift_stage;
   logic [CHANNELS-1:0] data_buffer;
   logic [CHANNELS-1:0] fault_latch;
   logic [CHANNELS-1:0] next_drive;
   logic [STAT_W-1:0] status;
   logic [STAT_W-1:0] mask;
   logic [STAT_W-1:0] status_set;
   logic status_read;
   logic prev_overtemp;
   logic prev_any_fault;
   logic force_off;

   // Gather the pins into one carrier
   always_comb begin
      raw_pins.shift_clk = shift_clk_i;
      raw_pins.serial_in = serial_in_i;
      raw_pins.latch_strobe = latch_strobe_i;
      raw_pins.enable_n = enable_n_i;
      raw_pins.overtemp_detect = overtemp_detect_i;
      raw_pins.undervolt_detect = undervolt_detect_i;
      raw_pins.overcurrent_detect = overcurrent_detect_i;
   end

   pin_filter #(
      .W($bits(pins_t)),
      .RST(PINS_RST)
   ) u_pins (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .async_i(raw_pins),
      .clean_o(pins)
   );

   // Edge history of the filtered shift clock and strobe
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         prev_shift_clk <= 1'b0;
         prev_strobe <= 1'b0;
      end else begin
         prev_shift_clk <= pins.shift_clk;
         prev_strobe <= pins.latch_strobe;
      end
   end

   assign shift_rise = pins.shift_clk & ~prev_shift_clk;
   assign strobe_fall = ~pins.latch_strobe & prev_strobe;
   assign force_off = pins.overtemp_detect | pins.undervolt_detect;

   // Shift register; last stage is the serial output for chaining
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         shift_stage <= CHAN_RST;
      end else if (shift_rise) begin
         shift_stage <= {shift_stage[CHANNELS-2:0], pins.serial_in};
      end
   end

   assign serial_out_o = shift_stage[CHANNELS-1];

   // Data buffer: cleared by under-voltage, transparent while strobe high and enabled, held otherwise
   always_ff @(posedge core_clk_i) begin
      if (rst_i || pins.undervolt_detect) begin
         data_buffer <= CHAN_RST;
      end else if (pins.latch_strobe && !pins.enable_n) begin
         data_buffer <= shift_stage;
      end
   end

   // Fault latches; a fresh over-current beats the strobe clear
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fault_latch <= CHAN_RST;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (pins.overcurrent_detect[i] && power_output_o[i]) begin
               fault_latch[i] <= 1'b1;
            end else if (strobe_fall) begin
               fault_latch[i] <= 1'b0;
            end
         end
      end
   end

   // Output drive; only a channel that is on can trip, others untouched
   always_comb begin
      next_drive = data_buffer & ~fault_latch;
      if (pins.enable_n || force_off) begin
         next_drive = CHAN_RST;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         power_output_o <= CHAN_RST;
      end else begin
         power_output_o <= next_drive;
      end
   end

   // Flag is the OR of all latches, active low
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fault_flag_n_o <= 1'b1;
      end else begin
         fault_flag_n_o <= ~|fault_latch;
      end
   end

   // Event history for the status register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         prev_overtemp <= 1'b0;
         prev_any_fault <= 1'b0;
      end else begin
         prev_overtemp <= pins.overtemp_detect;
         prev_any_fault <= |fault_latch;
      end
   end

   always_comb begin
      status_set = STAT_RST;
      status_set[STAT_FAULT] = |fault_latch & ~prev_any_fault;
      status_set[STAT_OVERTEMP] = pins.overtemp_detect & ~prev_overtemp;
      status_set[STAT_LATCHED] = strobe_fall & ~pins.enable_n;
   end

   assign status_read = reg_read_i && (reg_addr_i == OFS_STATUS);

   // Sticky status, cleared by reading it; a same-cycle event survives
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         status <= STAT_RST;
      end else if (status_read) begin
         status <= status_set;
      end else begin
         status <= status | status_set;
      end
   end

   // Mask register, the only writable one
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mask <= MASK_RST;
      end else if (reg_write_i && reg_addr_i == OFS_MASK) begin
         mask <= reg_wdata_i[STAT_W-1:0];
      end
   end

   // Level interrupt, one cycle behind the status bits
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status & mask);
      end
   end

   // Read data stand only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !reg_read_i) begin
         reg_rdata_o <= RDATA_RST;
      end else if (reg_addr_i == OFS_STATUS) begin
         reg_rdata_o <= {{(DATA_W-STAT_W){1'b0}}, status};
      end else if (reg_addr_i == OFS_MASK) begin
         reg_rdata_o <= {{(DATA_W-STAT_W){1'b0}}, mask};
      end else if (reg_addr_i == OFS_DRIVE) begin
         reg_rdata_o <= power_output_o;
      end else if (reg_addr_i == OFS_FAULT) begin
         reg_rdata_o <= fault_latch;
      end else begin
         reg_rdata_o <= RDATA_RST;
      end
   end

   // Checks that tie outputs to their causes
   sequence s_fault_sets;
      !rst_i && $rose(fault_latch != CHAN_RST);
   endsequence

   sequence s_strobe_clean;
      strobe_fall && pins.overcurrent_detect == CHAN_RST;
   endsequence

   property p_trip_one;
      @(posedge core_clk_i) disable iff (rst_i)
      (fault_latch != $past(fault_latch))
         |=> ((power_output_o & $past(fault_latch)) == CHAN_RST);
   endproperty
   a_trip_one: assert property (p_trip_one) else $error("tripped channel still on");

   property p_rearm;
      @(posedge core_clk_i) disable iff (rst_i)
      s_strobe_clean |=> fault_latch == CHAN_RST;
   endproperty
   a_rearm: assert property (p_rearm) else $error("fault latch not cleared");

   property p_flag;
      @(posedge core_clk_i) disable iff (rst_i)
      s_fault_sets |=> !fault_flag_n_o ##1 (!fault_flag_n_o || $past(strobe_fall, 2));
   endproperty
   a_flag: assert property (p_flag) else $error("fault flag not low");

   property p_hold;
      @(posedge core_clk_i) disable iff (rst_i)
      (fault_latch != CHAN_RST) && !strobe_fall |=> (fault_latch & $past(fault_latch))
         == $past(fault_latch);
   endproperty
   a_hold: assert property (p_hold) else $error("fault latch dropped early");

   property p_overtemp;
      @(posedge core_clk_i) disable iff (rst_i)
      pins.overtemp_detect [*2] |-> power_output_o == CHAN_RST;
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("output on in overtemp");

   property p_chain;
      @(posedge core_clk_i) disable iff (rst_i)
      shift_rise |=> serial_out_o == $past(shift_stage[CHANNELS-2]);
   endproperty
   a_chain: assert property (p_chain) else $error("serial out wrong stage");

   property p_bits;
      @(posedge core_clk_i) disable iff (rst_i)
      !pins.enable_n && !force_off |=> power_output_o ==
         ($past(data_buffer) & ~$past(fault_latch));
   endproperty
   a_bits: assert property (p_bits) else $error("output not per latched bit");

   property p_gate;
      @(posedge core_clk_i) disable iff (rst_i)
      pins.enable_n && !pins.undervolt_detect |=> $stable(data_buffer);
   endproperty
   a_gate: assert property (p_gate) else $error("buffer loaded while disabled");

   property p_shift;
      @(posedge core_clk_i) disable iff (rst_i)
      shift_rise |=> shift_stage[0] == $past(pins.serial_in);
   endproperty
   a_shift: assert property (p_shift) else $error("serial bit not captured");

   property p_pass;
      @(posedge core_clk_i) disable iff (rst_i)
      pins.latch_strobe && !pins.enable_n && !pins.undervolt_detect
         |=> data_buffer == $past(shift_stage);
   endproperty
   a_pass: assert property (p_pass) else $error("buffer not transparent");

   property p_disable;
      @(posedge core_clk_i) disable iff (rst_i)
      pins.enable_n |=> power_output_o == CHAN_RST;
   endproperty
   a_disable: assert property (p_disable) else $error("output on while disabled");

   property p_reset_off;
      @(posedge core_clk_i)
      rst_i || pins.undervolt_detect |=> power_output_o == CHAN_RST;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("output on after reset");

   // Serial output only moves on a shift, so it is the held last stage
   property p_eight_late;
      @(posedge core_clk_i) disable iff (rst_i)
      !shift_rise |=> $stable(serial_out_o);
   endproperty
   a_eight_late: assert property (p_eight_late) else $error("serial out not last stage");

endmodule

// ==== sim/serial_host_model.sv ====
// Purpose: Serial host model driving shift clock, data and strobe pins
// Assumes: Bit period 407.3 ns, unrelated in phase to the core clock
// Notes: Shift clock parks low between frames; data shows its inverse then
`timescale 1ns/10ps
module serial_host_model (
   output logic shift_clk_o,
   output logic serial_in_o,
   output logic latch_strobe_o
);
   // Idle pins at time zero
   initial begin
      shift_clk_o = 1'b0;
      serial_in_o = 1'b0;
      latch_strobe_o = 1'b0;
   end

   // One bit, set up half a period before the rising edge
   task automatic shift_bit(input logic b);
      #7.3;
      serial_in_o = b;
      #200 shift_clk_o = 1'b1;
      #200 shift_clk_o = 1'b0;
   endtask

   // Strobe pulse; the data line no longer holds a valid bit here
   task automatic strobe();
      serial_in_o = ~serial_in_o;
      #200 latch_strobe_o = 1'b1;
      #400 latch_strobe_o = 1'b0;
      #200;
   endtask
endmodule

// ==== sim/test_serial_octal_driver_control.sv ====
// Purpose: Self-checking bench for the octal driver control block
// Assumes: Pins settle through the samplers within ten core cycles
// Notes: First bit shifted lands on the eighth output
`timescale 1ns/10ps
module test_serial_octal_driver_control import octal_drv_pkg::*;;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   wire logic shift_clk, serial_in, latch_strobe;
   logic enable_n = 1'b0;
   logic overtemp = 1'b0;
   logic undervolt = 1'b0;
   logic [CHANNELS-1:0] overcurrent = 8'h00;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [DATA_W-1:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [CHANNELS-1:0] power_output;
   logic serial_out, fault_flag_n, irq;
   int fail_count = 0;
   int comparisons = 0;

   // 20 MHz core clock
   always #25 core_clk_i = ~core_clk_i;

   serial_host_model host (.shift_clk_o(shift_clk), .serial_in_o(serial_in),
      .latch_strobe_o(latch_strobe));

   octal_drv_ctrl DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .shift_clk_i(shift_clk),
      .serial_in_i(serial_in), .latch_strobe_i(latch_strobe), .enable_n_i(enable_n),
      .overtemp_detect_i(overtemp), .undervolt_detect_i(undervolt),
      .overcurrent_detect_i(overcurrent), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_rdata_o(reg_rdata),
      .power_output_o(power_output), .serial_out_o(serial_out),
      .fault_flag_n_o(fault_flag_n), .irq_o(irq));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Waits land one step past the edge so outputs have settled
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task automatic reg_write_op(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk_i);
      reg_write <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic reg_read_op(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk_i);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic read_check(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string w);
      logic [DATA_W-1:0] d;
      reg_read_op(a, d);
      check(d, exp, w);
   endtask

   task automatic shift_word(input logic [7:0] w);
      for (int i = 7; i >= 0; i--) host.shift_bit(w[i]);
   endtask

   task automatic load(input logic [7:0] w);
      shift_word(w);
      host.strobe();
      wait_cyc(10);
   endtask

   task automatic t_reset();
      check(power_output, 8'h00, "outputs after reset");
      check({7'h00, fault_flag_n}, 8'h01, "flag after reset");
      check({7'h00, irq}, 8'h00, "irq after reset");
      read_check(OFS_STATUS, 8'h00, "status reset");
      read_check(OFS_MASK, 8'h00, "mask reset");
      read_check(OFS_DRIVE, 8'h00, "drive reset");
      read_check(OFS_FAULT, 8'h00, "fault reset");
      read_check(4'h2, 8'h00, "unmapped read");
      reg_write_op(OFS_MASK, 8'hff);
      read_check(OFS_MASK, 8'h07, "mask width");
      reg_write_op(OFS_MASK, 8'h00);
   endtask

   task automatic t_table();
      logic [7:0] words [7] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0f, 8'hf0, 8'hff};
      foreach (words[i]) begin
         load(words[i]);
         check(power_output, words[i], "latched word");
         read_check(OFS_DRIVE, words[i], "drive read");
      end
   endtask

   task automatic t_enable();
      @(posedge core_clk_i);
      enable_n <= 1'b1;
      wait_cyc(10);
      check(power_output, 8'h00, "enable high");
      load(8'h00);
      @(posedge core_clk_i);
      enable_n <= 1'b0;
      wait_cyc(10);
      check(power_output, 8'hff, "load gated by enable");
   endtask

   // Strobe held high: buffer follows the register, even mid-shift
   task automatic t_transparent();
      shift_word(8'h5a);
      host.latch_strobe_o = 1'b1;
      wait_cyc(10);
      check(power_output, 8'h5a, "transparent");
      host.shift_bit(1'b1);
      wait_cyc(10);
      check(power_output, 8'hb5, "transparent shift");
      host.latch_strobe_o = 1'b0;
      host.shift_bit(1'b0);
      wait_cyc(10);
      check(power_output, 8'hb5, "held after fall");
   endtask

   task automatic t_fault();
      logic [DATA_W-1:0] d;
      load(8'hff);
      reg_read_op(OFS_STATUS, d);
      reg_write_op(OFS_MASK, 8'h01);
      @(posedge core_clk_i);
      overcurrent <= 8'h04;
      wait_cyc(10);
      check(power_output, 8'hfb, "one channel off");
      check({7'h00, fault_flag_n}, 8'h00, "flag low");
      check({7'h00, irq}, 8'h01, "irq raised");
      read_check(OFS_STATUS, 8'h01, "fault status");
      wait_cyc(2);
      check({7'h00, irq}, 8'h00, "irq cleared by read");
      @(posedge core_clk_i);
      overcurrent <= 8'h00;
      wait_cyc(10);
      check({7'h00, fault_flag_n}, 8'h00, "flag held");
      read_check(OFS_FAULT, 8'h04, "fault latch held");
      load(8'hff);
      check(power_output, 8'hff, "channel back on");
      check({7'h00, fault_flag_n}, 8'h01, "flag cleared");
      reg_write_op(OFS_MASK, 8'h00);
   endtask

   task automatic t_overtemp_undervolt();
      logic [DATA_W-1:0] d;
      reg_read_op(OFS_STATUS, d);
      @(posedge core_clk_i);
      overtemp <= 1'b1;
      wait_cyc(10);
      check(power_output, 8'h00, "overtemp off");
      read_check(OFS_STATUS, 8'h02, "overtemp status");
      @(posedge core_clk_i);
      overtemp <= 1'b0;
      wait_cyc(10);
      check(power_output, 8'hff, "overtemp cleared");
      @(posedge core_clk_i);
      undervolt <= 1'b1;
      wait_cyc(10);
      check(power_output, 8'h00, "undervolt off");
      @(posedge core_clk_i);
      undervolt <= 1'b0;
      wait_cyc(10);
      check(power_output, 8'h00, "buffer cleared");
   endtask

   // Sixteen bits: the first byte leaves on the serial output
   task automatic t_cascade();
      logic [7:0] first = 8'ha5;
      logic [7:0] second = 8'h3c;
      shift_word(first);
      // Last stage shows each first-byte bit until the next shift pushes it out
      for (int i = 7; i >= 0; i--) begin
         wait_cyc(4);
         check({7'h00, serial_out}, {7'h00, first[i]}, "serial out");
         host.shift_bit(second[i]);
      end
      host.strobe();
      wait_cyc(10);
      check(power_output, second, "last byte kept");
      read_check(OFS_STATUS, 8'h04, "word latched status");
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog well past the expected run time
   initial begin
      #1ms;
      fail_count++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(posedge core_clk_i);
      rst_i <= 1'b0;
      wait_cyc(2);
      t_reset();
      t_table();
      t_enable();
      t_transparent();
      t_fault();
      t_overtemp_undervolt();
      t_cascade();
      report_and_stop();
   end
endmodule
